/* File: rtl/dcp_pkg.sv */
// ============================================================
// Shared constants for the two-rail compensator and pulse engines
package dcp_pkg;
   // Sizes of the datapath
   localparam int RAILS   = 2;
   localparam int DATA_W  = 32;
   localparam int ADDR_W  = 8;
   localparam int RAW_W   = 8;
   localparam int ERR_W   = 6;
   localparam int GAIN_W  = 8;
   localparam int SIG_W   = 18;
   localparam int COEF_W  = 16;
   localparam int NCOEF   = 8;
   localparam int NBANK   = 3;
   localparam int DUTY_W  = 12;
   localparam int PER_W   = 16;
   localparam int IOUT_W  = 12;
   localparam int FRAC    = 12;
   localparam int ACC_W   = 37;

   // Error converter clamp points in LSBs, then the duty code ceiling
   localparam logic signed [ERR_W-1:0] ERR_MIN  = 6'sh20;
   localparam logic signed [ERR_W-1:0] ERR_MAX  = 6'sh1F;
   localparam logic [DUTY_W-1:0]       DUTY_MAX = 12'hFFF;

   // Coefficient banks
   localparam logic [1:0] BANK_RAMP  = 2'h0;
   localparam logic [1:0] BANK_REG   = 2'h1;
   localparam logic [1:0] BANK_LIGHT = 2'h2;

   // Ramp reset sources
   localparam logic [1:0] SRC_FREE = 2'h0;
   localparam logic [1:0] SRC_ENG1 = 2'h1;
   localparam logic [1:0] SRC_ENG2 = 2'h2;
   localparam logic [1:0] SRC_EXT  = 2'h3;

   // Per-rail register block: rail r sits at r * RAIL_STRIDE
   localparam logic [ADDR_W-1:0] RAIL_STRIDE   = 8'h10;
   localparam logic [3:0]        OFS_CTRL      = 4'h0;
   localparam logic [3:0]        OFS_PERIOD    = 4'h1;
   localparam logic [3:0]        OFS_PHASE     = 4'h2;
   localparam logic [3:0]        OFS_EXT_DELAY = 4'h3;
   localparam logic [3:0]        OFS_LIMITS    = 4'h4;
   localparam logic [3:0]        OFS_GAINS_LO  = 4'h5;
   localparam logic [3:0]        OFS_GAINS_HI  = 4'h6;
   localparam logic [3:0]        OFS_LIGHT     = 4'h7;
   localparam logic [3:0]        OFS_STATUS    = 4'h8;
   localparam logic [ADDR_W-1:0] REG_SYNC_SEL  = 8'h20;
   localparam logic [1:0]        COEF_PAGE     = 2'h1;

   // Field positions inside the control register
   localparam int CTRL_EN_BIT  = 0;
   localparam int CTRL_SRC_LSB = 1;

   // Values after reset
   localparam logic [PER_W-1:0]  PERIOD_RST = 16'h0064;
   localparam logic [GAIN_W-1:0] GAIN_RST   = 8'h01;
   localparam logic [COEF_W-1:0] UNITY_COEF = 16'h1000;
endpackage

/* File: rtl/dcp_nl_gain.sv */
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// Nonlinear gain stage: five gains over four error thresholds
module dcp_nl_gain (
   input  wire logic                                       REF_CLK,
   input  wire logic                                       RST,
   input  wire logic                                       in_vld,
   input  wire logic signed [dcp_pkg::ERR_W-1:0]           err,
   input  wire logic [3:0][dcp_pkg::ERR_W-1:0]             limits,
   input  wire logic [4:0][dcp_pkg::GAIN_W-1:0]            gains,
   output logic signed [dcp_pkg::SIG_W-1:0]                u,
   output logic                                            u_vld
);
   import dcp_pkg::*;

   typedef struct packed {
      logic signed [SIG_W-1:0] u;
      logic                    vld;
   } dcp_gain_st_t;

   dcp_gain_st_t s, next_s;
   logic [GAIN_W-1:0] g;

   // ============================================================
   // Band select: limits need not be symmetric or even signed
   always_comb begin
      next_s = s;
      g = gains[4];
      if (err < $signed(limits[0])) g = gains[0];        // [RULE3] [RULE4]
      else if (err < $signed(limits[1])) g = gains[1];
      else if (err < $signed(limits[2])) g = gains[2];
      else if (err < $signed(limits[3])) g = gains[3];
      next_s.vld = in_vld;
      if (in_vld) next_s.u = SIG_W'(err * $signed({1'b0, g})); // [RULE1]
   end

   always_ff @(posedge REF_CLK) begin
      if (RST) s <= '0;
      else s <= next_s;
   end

   assign u     = s.u;
   assign u_vld = s.vld;

   AST_LOW_BAND: assert property (@(posedge REF_CLK) disable iff (RST) // [RULE3]
      in_vld && err < $signed(limits[0])
      |=> u == SIG_W'($past(err) * $signed({1'b0, $past(gains[0])})))
      else $error("lowest band did not use the first gain");
endmodule
`default_nettype wire

/* File: rtl/dcp_pulse_engine.sv */
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// Pulse engine: period counter, compare threshold, phase sync
module dcp_pulse_engine (
   input  wire logic                        REF_CLK,
   input  wire logic                        RST,
   input  wire logic                        en,
   input  wire logic [dcp_pkg::PER_W-1:0]   period,
   input  wire logic [dcp_pkg::DUTY_W-1:0]  duty,
   input  wire logic                        ramp_rst,
   input  wire logic [dcp_pkg::PER_W-1:0]   phase,
   output logic                             pwm,
   output logic                             sync_p
);
   import dcp_pkg::*;

   typedef struct packed {
      logic [PER_W-1:0] cnt;
      logic [PER_W-1:0] thr;
      logic             pwm;
      logic             sync;
   } dcp_pe_st_t;

   dcp_pe_st_t s, next_s;
   logic [PER_W+DUTY_W-1:0] prod;

   // ============================================================
   // Threshold is only reloaded at period start, so no runt pulses
   always_comb begin
      next_s = s;
      prod = duty * period;                                  // [RULE7]
      if (ramp_rst || s.cnt + 16'h0001 >= period) begin      // [RULE10]
         next_s.cnt = '0;
         next_s.thr = prod[PER_W+DUTY_W-1:DUTY_W];
      end else begin
         next_s.cnt = s.cnt + 16'h0001;
      end
      next_s.pwm  = en && (next_s.cnt < next_s.thr);         // [RULE8]
      next_s.sync = en && (next_s.cnt == phase);             // [RULE21] [RULE12]
   end

   always_ff @(posedge REF_CLK) begin
      if (RST) s <= '0;
      else s <= next_s;
   end

   assign pwm    = s.pwm;
   assign sync_p = s.sync;

   AST_RAMP_RESET: assert property (@(posedge REF_CLK) disable iff (RST) // [RULE10]
      ramp_rst |=> s.cnt == '0)
      else $error("ramp reset did not clear the counter");
   AST_THRESHOLD: assert property (@(posedge REF_CLK) disable iff (RST) // [RULE7]
      ramp_rst |=> s.thr == PER_W'(({16'h0000, $past(duty)} * $past(period)) >> DUTY_W))
      else $error("threshold not duty times period");
   AST_PWM_COMPARE: assert property (@(posedge REF_CLK) disable iff (RST) // [RULE8]
      pwm == (($past(en) && s.cnt < s.thr)))
      else $error("pulse does not follow the compare");
endmodule
`default_nettype wire

/* File: rtl/dcp_top.sv */
// Behaviour
// (RULE1) Error passes nonlinear gain, then second-order IIR, then first-order IIR.
// (RULE2) Bank 0 in ramps or tracking, bank 1 regulating, bank 2 light load.
// (RULE3) Gain applied depends on the band the error falls into.
// (RULE4) Four thresholds programmable independently; first gain covers below lowest.
// (RULE5) First-order section forms the third zero and third pole.
// (RULE6) Compensator output is a duty fraction, 0 to 100 percent; code saturates at DUTY_MAX, just under 100 percent.
// (RULE7) Threshold is duty value times configured period.
// (RULE8) Threshold compared with period counter forms the gate pulse.
// (RULE9) Two single-phase rails; pulse channel equals feedback channel.
// (RULE10) A sync signal resets each engine's ramp counter.
// (RULE11) Ramp reset source: free run, engine 1, engine 2, external input.
// (RULE12) Each engine emits a phase-delayed sync to engines or external output.
// (RULE13) Software gives internally synchronised engines the same frequency.
// (RULE14) Software sets sample trigger to minimum for internal sync.
// (RULE15) External sync must be faster than the programmed switching frequency.
// (RULE16) Sample trigger under external sync meets the margin formula.
// (RULE17) Rails sharing an internal sync source get identical phase delays.
// (RULE18) External-source delay comes from its own register, separate from internal.
// (RULE19) Software should set the external-source delay to zero.
// (RULE20) Converter error is clamped to -32 or 31 LSBs.
// (RULE21) Phase sync pulses one cycle when counter equals phase delay.
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// Two-rail compensator datapath with pulse engines and sync routing
module dcp_top (
   input  wire logic                                                  REF_CLK,
   input  wire logic                                                  RST,
   input  wire logic [dcp_pkg::ADDR_W-1:0]                            ADDR,
   input  wire logic [dcp_pkg::DATA_W-1:0]                            WDATA,
   input  wire logic                                                  WR,
   input  wire logic                                                  RD,
   output logic [dcp_pkg::DATA_W-1:0]                                 RDATA,
   input  wire logic [dcp_pkg::RAILS-1:0][dcp_pkg::RAW_W-1:0]         ERR_CODE,
   input  wire logic [dcp_pkg::RAILS-1:0]                             ERR_VALID,
   input  wire logic [dcp_pkg::RAILS-1:0]                             RAMP_ACTIVE,
   input  wire logic [dcp_pkg::RAILS-1:0][dcp_pkg::IOUT_W-1:0]        IOUT,
   input  wire logic                                                  EXTERNAL_SYNC_INPUT,
   output logic                                                       EXTERNAL_SYNC_OUTPUT,
   output logic [dcp_pkg::RAILS-1:0]                                  GATE_PWM
);
   import dcp_pkg::*;

   typedef struct packed {
      logic [RAILS-1:0]                                  en;
      logic [RAILS-1:0][1:0]                             src;
      logic [RAILS-1:0][PER_W-1:0]                       period;
      logic [RAILS-1:0][PER_W-1:0]                       phase;
      logic [RAILS-1:0][PER_W-1:0]                       ext_dly;
      logic [RAILS-1:0][3:0][ERR_W-1:0]                  limits;
      logic [RAILS-1:0][4:0][GAIN_W-1:0]                 gains;
      logic [RAILS-1:0][IOUT_W-1:0]                      light;
      logic [RAILS-1:0][NBANK-1:0][NCOEF-1:0][COEF_W-1:0] coef;
      logic [1:0]                                        out_sel;
      logic [RAILS-1:0][SIG_W-1:0]                       u1;
      logic [RAILS-1:0][SIG_W-1:0]                       u2;
      logic [RAILS-1:0][SIG_W-1:0]                       y1;
      logic [RAILS-1:0][SIG_W-1:0]                       y2;
      logic [RAILS-1:0][SIG_W-1:0]                       z1;
      logic [RAILS-1:0][DUTY_W-1:0]                      duty;
      logic [RAILS-1:0][1:0]                             bank;
      logic [RAILS-1:0][PER_W-1:0]                       ext_cnt;
      logic [RAILS-1:0]                                  ext_busy;
      logic [RAILS-1:0]                                  eng_rst;
      logic                                              ext_prev;
      logic                                              ext_out;
      logic [DATA_W-1:0]                                 rdata;
   } dcp_top_st_t;

   dcp_top_st_t s, next_s;

   logic [RAILS-1:0][ERR_W-1:0] err_clamp;
   logic [RAILS-1:0][SIG_W-1:0] u;
   logic [RAILS-1:0]            u_vld;
   logic [RAILS-1:0]            sync_p;
   logic [RAILS-1:0]            pwm;
   logic                        ext_edge;

   // ============================================================
   // Address decoding shared by the write and read paths
   function automatic logic rail_hit(input logic [ADDR_W-1:0] a, input int r);
      return a[ADDR_W-1:4] == 4'(r);
   endfunction

   function automatic logic coef_hit(input logic [ADDR_W-1:0] a);
      return a[7:6] == COEF_PAGE && a[4:3] != 2'h3;
   endfunction

   // Saturate a wide accumulator after dropping the fraction bits
   function automatic logic signed [SIG_W-1:0] sat_sig(input logic signed [ACC_W-1:0] v);
      logic signed [ACC_W-1:0] t;
      t = v >>> FRAC;
      if (t > $signed(ACC_W'(18'sh1FFFF))) return 18'sh1FFFF;
      else if (t < $signed({{(ACC_W-SIG_W){1'b1}}, 18'sh20000})) return 18'sh20000;
      else return t[SIG_W-1:0];
   endfunction

   // ============================================================
   // Per-rail datapath: each engine is wired to its own feedback channel
   genvar gr;
   generate
      for (gr = 0; gr < RAILS; gr++) begin : g_rail
         // Saturated converter codes never leave the six-bit range
         always_comb begin
            if ($signed(ERR_CODE[gr]) > $signed(RAW_W'(ERR_MAX))) err_clamp[gr] = ERR_MAX;
            else if ($signed(ERR_CODE[gr]) < $signed({2'b11, ERR_MIN}))
               err_clamp[gr] = ERR_MIN;                             // [RULE20]
            else err_clamp[gr] = ERR_CODE[gr][ERR_W-1:0];
         end

         dcp_nl_gain u_gain (
            .REF_CLK (REF_CLK),
            .RST     (RST),
            .in_vld  (ERR_VALID[gr]),
            .err     (err_clamp[gr]),
            .limits  (s.limits[gr]),
            .gains   (s.gains[gr]),
            .u       (u[gr]),
            .u_vld   (u_vld[gr])
         );

         // Same index from feedback to gate output, no remapping
         dcp_pulse_engine u_engine (
            .REF_CLK  (REF_CLK),
            .RST      (RST),
            .en       (s.en[gr]),
            .period   (s.period[gr]),
            .duty     (s.duty[gr]),
            .ramp_rst (s.eng_rst[gr]),
            .phase    (s.phase[gr]),
            .pwm      (pwm[gr]),
            .sync_p   (sync_p[gr])
         );                                                         // [RULE9]
      end
   endgenerate

   // ============================================================
   // Register file, compensator filters and ramp reset routing
   always_comb begin
      logic [1:0]              bsel;
      logic signed [ACC_W-1:0] acc;
      logic signed [SIG_W-1:0] y;
      logic signed [SIG_W-1:0] z;
      logic [NCOEF-1:0][COEF_W-1:0] c;
      bsel = BANK_REG;
      acc  = '0;
      y    = '0;
      z    = '0;
      c    = '0;
      next_s         = s;
      next_s.rdata   = '0;
      next_s.eng_rst = '0;
      next_s.ext_prev = EXTERNAL_SYNC_INPUT;
      ext_edge = EXTERNAL_SYNC_INPUT & ~s.ext_prev;

      // Software writes
      if (WR) begin
         for (int r = 0; r < RAILS; r++) begin
            if (rail_hit(ADDR, r)) begin
               case (ADDR[3:0])
                  OFS_CTRL: begin
                     next_s.en[r]  = WDATA[CTRL_EN_BIT];
                     next_s.src[r] = WDATA[CTRL_SRC_LSB +: 2];       // [RULE11]
                  end
                  OFS_PERIOD:    next_s.period[r]  = WDATA[PER_W-1:0];
                  OFS_PHASE:     next_s.phase[r]   = WDATA[PER_W-1:0];
                  OFS_EXT_DELAY: next_s.ext_dly[r] = WDATA[PER_W-1:0]; // [RULE18]
                  OFS_LIMITS:    next_s.limits[r]  = WDATA[4*ERR_W-1:0]; // [RULE4]
                  OFS_GAINS_LO:  next_s.gains[r][3:0] = WDATA;
                  OFS_GAINS_HI:  next_s.gains[r][4] = WDATA[GAIN_W-1:0];
                  OFS_LIGHT:     next_s.light[r] = WDATA[IOUT_W-1:0];
                  default: ;
               endcase
            end
         end
         if (ADDR == REG_SYNC_SEL) next_s.out_sel = WDATA[1:0];
         if (coef_hit(ADDR)) next_s.coef[ADDR[5]][ADDR[4:3]][ADDR[2:0]] = WDATA[COEF_W-1:0];
      end

      // Software reads: data stand in the following cycle only
      if (RD) begin
         for (int r = 0; r < RAILS; r++) begin
            if (rail_hit(ADDR, r)) begin
               case (ADDR[3:0])
                  OFS_CTRL:      next_s.rdata = DATA_W'({s.src[r], s.en[r]});
                  OFS_PERIOD:    next_s.rdata = DATA_W'(s.period[r]);
                  OFS_PHASE:     next_s.rdata = DATA_W'(s.phase[r]);
                  OFS_EXT_DELAY: next_s.rdata = DATA_W'(s.ext_dly[r]);
                  OFS_LIMITS:    next_s.rdata = DATA_W'(s.limits[r]);
                  OFS_GAINS_LO:  next_s.rdata = s.gains[r][3:0];
                  OFS_GAINS_HI:  next_s.rdata = DATA_W'(s.gains[r][4]);
                  OFS_LIGHT:     next_s.rdata = DATA_W'(s.light[r]);
                  OFS_STATUS:    next_s.rdata = DATA_W'({pwm[r], s.bank[r], s.duty[r]});
                  default:       next_s.rdata = '0;
               endcase
            end
         end
         if (ADDR == REG_SYNC_SEL) next_s.rdata = DATA_W'(s.out_sel);
         if (coef_hit(ADDR)) next_s.rdata = DATA_W'(s.coef[ADDR[5]][ADDR[4:3]][ADDR[2:0]]);
      end

      for (int r = 0; r < RAILS; r++) begin
         // Ramps win over light load, so start-up never uses the light bank
         if (RAMP_ACTIVE[r]) bsel = BANK_RAMP;                      // [RULE2]
         else if (IOUT[r] < s.light[r]) bsel = BANK_LIGHT;
         else bsel = BANK_REG;
         c = s.coef[r][bsel];

         // One new duty value per gained error sample
         if (u_vld[r]) begin
            acc = ACC_W'($signed(c[0]) * $signed(u[r]))             // [RULE1]
                + ACC_W'($signed(c[1]) * $signed(s.u1[r]))
                + ACC_W'($signed(c[2]) * $signed(s.u2[r]))
                + ACC_W'($signed(c[3]) * $signed(s.y1[r]))
                + ACC_W'($signed(c[4]) * $signed(s.y2[r]));
            y = sat_sig(acc);
            acc = ACC_W'($signed(c[5]) * y)                         // [RULE5]
                + ACC_W'($signed(c[6]) * $signed(s.y1[r]))
                + ACC_W'($signed(c[7]) * $signed(s.z1[r]));
            z = sat_sig(acc);
            next_s.u2[r] = s.u1[r];
            next_s.u1[r] = u[r];
            next_s.y2[r] = s.y1[r];
            next_s.y1[r] = y;
            next_s.z1[r] = z;
            next_s.bank[r] = bsel;
            // Negative effort means zero duty; full scale saturates at DUTY_MAX, just under 100 percent
            if (z < 0) next_s.duty[r] = '0;                         // [RULE6]
            else if (z > $signed({6'h00, DUTY_MAX})) next_s.duty[r] = DUTY_MAX;
            else next_s.duty[r] = z[DUTY_W-1:0];
         end

         // Ramp reset routing; internal sources already carry their phase delay
         case (s.src[r])
            SRC_ENG1: next_s.eng_rst[r] = sync_p[0];                // [RULE11] [RULE12]
            SRC_ENG2: next_s.eng_rst[r] = sync_p[1];
            SRC_EXT: begin
               // Separate delay register; a nonzero value costs loop phase
               if (s.ext_busy[r]) begin
                  next_s.ext_cnt[r] = s.ext_cnt[r] - 16'h0001;
                  if (s.ext_cnt[r] == 16'h0001) begin
                     next_s.ext_busy[r] = 1'b0;
                     next_s.eng_rst[r]  = 1'b1;                     // [RULE18]
                  end
               end
               if (ext_edge) begin
                  if (s.ext_dly[r] == '0) begin
                     next_s.eng_rst[r]  = 1'b1;                     // [RULE10]
                     next_s.ext_busy[r] = 1'b0;
                  end else begin
                     next_s.ext_cnt[r]  = s.ext_dly[r];
                     next_s.ext_busy[r] = 1'b1;
                  end
               end
            end
            default: next_s.ext_busy[r] = 1'b0;
         endcase
      end

      // Daisy chain to other controllers
      case (s.out_sel)
         SRC_ENG1: next_s.ext_out = sync_p[0];                      // [RULE12]
         SRC_ENG2: next_s.ext_out = sync_p[1];
         default:  next_s.ext_out = 1'b0;
      endcase
   end

   // ============================================================
   // State register with reset values
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         s <= '0;
         for (int r = 0; r < RAILS; r++) begin
            s.period[r] <= PERIOD_RST;
            s.bank[r]   <= BANK_REG;
            for (int k = 0; k < 5; k++) begin
               s.gains[r][k] <= GAIN_RST;
            end
            for (int b = 0; b < NBANK; b++) begin
               s.coef[r][b][0] <= UNITY_COEF;
               s.coef[r][b][5] <= UNITY_COEF;
            end
         end
      end else begin
         s <= next_s;
      end
   end

   assign RDATA                = s.rdata;
   assign EXTERNAL_SYNC_OUTPUT = s.ext_out;
   assign GATE_PWM             = pwm;

   // ============================================================
   // Checks
   sequence ext_edge_delayed_s;
      ext_edge && s.src[0] == SRC_EXT && s.ext_dly[0] == 16'h0003 && !s.ext_busy[0];
   endsequence
   sequence rst_after_three_s;
      !s.eng_rst[0] ##1 !s.eng_rst[0] ##1 !s.eng_rst[0] ##1 s.eng_rst[0];
   endsequence

   AST_ERR_CLAMP: assert property (@(posedge REF_CLK) disable iff (RST) // [RULE20]
      $signed(ERR_CODE[0]) > 8'sh1F |-> err_clamp[0] == ERR_MAX)
      else $error("saturated error not clamped to 31");
   AST_BANK_RAMP: assert property (@(posedge REF_CLK) disable iff (RST) // [RULE2]
      u_vld[0] && RAMP_ACTIVE[0] |=> s.bank[0] == BANK_RAMP)
      else $error("ramp did not use bank 0");
   AST_BANK_LIGHT: assert property (@(posedge REF_CLK) disable iff (RST) // [RULE2]
      u_vld[0] && !RAMP_ACTIVE[0] && IOUT[0] < s.light[0] |=> s.bank[0] == BANK_LIGHT)
      else $error("light load did not use bank 2");
   AST_DUTY_UPDATE: assert property (@(posedge REF_CLK) disable iff (RST) // [RULE6]
      !u_vld[0] |=> $stable(s.duty[0]))
      else $error("duty moved without a new sample");
   AST_CHAIN_RESET: assert property (@(posedge REF_CLK) disable iff (RST) // [RULE11]
      s.src[1] == SRC_ENG1 && sync_p[0] |=> s.eng_rst[1])
      else $error("engine 2 missed the chained reset");
   AST_EXT_DELAY: assert property (@(posedge REF_CLK) disable iff (RST) // [RULE18]
      ext_edge_delayed_s ##0 (s.src[0] == SRC_EXT) [*1] |=> rst_after_three_s)
      else $error("external delay not honoured");
   AST_EXT_OUT: assert property (@(posedge REF_CLK) disable iff (RST) // [RULE12]
      s.out_sel == SRC_ENG1 |=> EXTERNAL_SYNC_OUTPUT == $past(sync_p[0]))
      else $error("sync output does not follow engine 1");
   AST_FREE_RUN: assert property (@(posedge REF_CLK) disable iff (RST) // [RULE11]
      s.src[0] == SRC_FREE |=> !s.eng_rst[0])
      else $error("free running engine was reset");
endmodule
`default_nettype wire

/* File: tb/dcp_sync_src.sv */
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// Far-side sync source: one rising edge every per cycles while run
module dcp_sync_src (
   input  wire logic       REF_CLK,
   input  wire logic       RST,
   input  wire logic       run,
   input  wire logic [7:0] per,
   output logic            sync
);
   logic [7:0] cnt;
   // Line rests low between bursts; two-cycle high keeps the edge clean
   always_ff @(posedge REF_CLK) begin
      if (RST || !run) begin
         cnt  <= 8'h00;
         sync <= 1'b0;
      end else begin
         cnt  <= (cnt == per - 8'h01) ? 8'h00 : cnt + 8'h01;
         sync <= (cnt < 8'h02);
      end
   end
endmodule
`default_nettype wire

/* File: tb/digital_compensator_pwm_sync_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; \
$display("BAD %s exp %h got %h", n, e, g); end end
// ============================================================
// Bench: register bus, error path, pulse width and sync routing
module digital_compensator_pwm_sync_tb;
   import dcp_pkg::*;
   logic clk = 0, rst = 1, wr = 0, rd = 0, run = 0, xs;
   logic [ADDR_W-1:0] addr = '0;
   logic [DATA_W-1:0] wd = '0, rdata, got;
   logic [1:0][RAW_W-1:0] code = '0;
   logic [1:0] ev = '0, ramp = '0, pwm;
   logic [1:0][IOUT_W-1:0] iout = '0;
   logic xo;
   int err_total = 0, n_compared = 0, hi, ps, hi1;
   dcp_top DUT (.REF_CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wd), .WR(wr), .RD(rd),
      .RDATA(rdata), .ERR_CODE(code), .ERR_VALID(ev), .RAMP_ACTIVE(ramp), .IOUT(iout),
      .EXTERNAL_SYNC_INPUT(xs), .EXTERNAL_SYNC_OUTPUT(xo), .GATE_PWM(pwm));
   dcp_sync_src far (.REF_CLK(clk), .RST(rst), .run(run), .per(8'h28), .sync(xs));
   initial begin
      forever #50 clk = ~clk;
   end
   task automatic report_and_stop;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // One-cycle strobes; read data caught in the cycle after the strobe
   task automatic wrr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk); addr <= a; wd <= d; wr <= 1'b1;
      @(posedge clk); wr <= 1'b0;
   endtask
   task automatic rdr(input logic [7:0] a);
      @(posedge clk); addr <= a; rd <= 1'b1;
      @(posedge clk); rd <= 1'b0;
      #1 got = rdata;
   endtask
   // Rail 0 sample, then status read once the duty has landed
   task automatic smp(input logic [7:0] c, input logic ra, input logic [13:0] e);
      @(posedge clk); code[0] <= c; ramp[0] <= ra; ev[0] <= 1'b1;
      @(posedge clk); ev[0] <= 1'b0;
      repeat (3) @(posedge clk);
      rdr(8'h08);
      `CHK("status", e, got[13:0])
   endtask
   // Gate high cycles and sync-out pulses over a window of n cycles
   task automatic win(input int n);
      hi = 0; ps = 0;
      hi1 = 0;
      repeat (n) begin
         @(posedge clk); #1;
         hi += pwm[0]; ps += xo;
         hi1 += pwm[1];
      end
   endtask
   initial begin
      #5000000 err_total++;
      report_and_stop();
   end
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      rdr(8'h01); `CHK("period rst", 32'h64, got)
      rdr(8'h30); `CHK("unmapped", 32'h0, got)
      wrr(8'h06, 32'h7F); wrr(8'h04, 32'h280000); wrr(8'h01, 32'h40);
      wrr(8'h00, 32'h1); wrr(8'h02, 32'h5); wrr(8'h20, 32'h1);
      // Rail 1 follows engine 1 at the same period; its duty stays zero
      wrr(8'h11, 32'h40);
      wrr(8'h12, 32'h5);
      wrr(8'h10, 32'h3);
      smp(8'h05, 1'b0, 14'h1005);
      smp(8'h7F, 1'b0, 14'h1F61);
      smp(8'h7F, 1'b1, 14'h0F61);
      wrr(8'h07, 32'h100);
      smp(8'hE0, 1'b0, 14'h2000);
      wrr(8'h07, 32'h0);
      smp(8'h1F, 1'b0, 14'h1F61);
      repeat (130) @(posedge clk);
      win(256);
      `CHK("hi free", 244, hi)
      `CHK("sync free", 4, ps)
      `CHK("hi rail1", 0, hi1)
      wrr(8'h00, 32'h7); run <= 1'b1;
      repeat (100) @(posedge clk);
      win(200);
      `CHK("hi ext", 200, hi)
      `CHK("sync ext", 5, ps)
      // Separate external delay of three cycles: same counts, later reset
      wrr(8'h03, 32'h3);
      repeat (60) @(posedge clk);
      win(200);
      `CHK("hi ext dly", 200, hi)
      `CHK("sync ext dly", 5, ps)
      report_and_stop();
   end
endmodule
`default_nettype wire
